// ==== rtl/xvc_calc.sv ====
// Calculation command block: user variable bank, X register, frame receiver and replier.
// Assumes a byte stream on the same clock from a link receiver and a byte sink for replies;
// a stored-program engine on the same clock may also hand whole commands in.
`timescale 1ns/10ps
`include "xvc_defs.svh"
module xvc_calc import xvc_pkg::*; #(
  parameter int VAR_COUNT = 256,
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR = 8'h02,
  parameter logic [7:0] BAD_TYPE_STATUS = 8'h03
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  input wire logic i_prog_valid,
  input wire xvc_cmd_s i_prog_cmd,
  output logic o_prog_ready,
  output logic o_prog_done,
  output logic [31:0] o_xreg,
  output logic o_cmp_zero,
  output logic o_cmp_less,
  input wire logic [7:0] i_peek_idx,
  output logic [31:0] o_peek_data,
  output logic o_cksum_err,
  output logic o_foreign_instr
);
  localparam int FRAME_BITS = 64;

  xvc_state_e state_reg;
  xvc_state_e state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [FRAME_BITS-1:0] rx_buf_reg;
  logic [FRAME_BITS-1:0] rx_buf_next;
  logic [7:0] rx_sum_reg;
  logic [7:0] rx_sum_next;
  xvc_cmd_s cmd_reg;
  xvc_cmd_s cmd_next;
  logic from_host_reg;
  logic from_host_next;
  logic [FRAME_BITS+7:0] tx_buf_reg;
  logic [FRAME_BITS+7:0] tx_buf_next;
  logic [31:0] xreg_reg;
  logic [31:0] xreg_next;
  logic cmp_zero_reg;
  logic cmp_zero_next;
  logic cmp_less_reg;
  logic cmp_less_next;
  logic done_reg;
  logic done_next;
  logic cksum_err_reg;
  logic cksum_err_next;
  logic foreign_reg;
  logic foreign_next;
  logic [31:0] peek_reg;
  logic [31:0] peek_next;

  logic [31:0] var_q [VAR_COUNT];
  logic [VAR_COUNT-1:0] var_we;
  logic [31:0] var_wdata;

  logic is_vx;
  logic is_xv;
  logic idx_ok;
  logic [31:0] var_rd;
  logic [31:0] alu_dst;
  logic [31:0] alu_src;
  xvc_alu_s alu_res;
  xvc_cmd_s rx_frame;
  xvc_reply_s reply;

  function automatic logic [7:0] frame_sum(input logic [FRAME_BITS-1:0] bytes);
    logic [7:0] acc;
    acc = `XVC_BYTE_ZERO;
    for (int i = 0; i < FRAME_BITS / `XVC_BYTE_BITS; i++) begin
      acc = acc + bytes[i*`XVC_BYTE_BITS +: `XVC_BYTE_BITS]; // R16
    end
    return acc;
  endfunction

  // Only the two calculation codes are executed; others belong to other command units.
  assign is_vx = (cmd_reg.instr == `XVC_INSTR_VAR_FROM_X); // R01
  assign is_xv = (cmd_reg.instr == `XVC_INSTR_X_FROM_VAR); // R02
  assign idx_ok = (32'(cmd_reg.var_idx) < VAR_COUNT); // R03
  assign var_rd = idx_ok ? var_q[cmd_reg.var_idx] : `XVC_WORD_ZERO;
  // Code 43 makes the variable the destination, code 44 makes X the destination.
  assign alu_dst = is_vx ? var_rd : xreg_reg; // R01 R02
  assign alu_src = is_vx ? xreg_reg : var_rd; // R01 R02
  // Received byte order is fixed, so the shift buffer maps straight onto the struct.
  assign rx_frame = xvc_cmd_s'(rx_buf_reg); // R13

  xvc_alu u_alu (
    .i_op(cmd_reg.op), // R03
    .i_dst(alu_dst),
    .i_src(alu_src),
    .o_res(alu_res)
  );

  // Handshakes are combinational; a program command waits while a host frame is partly in.
  assign o_rx_ready = (state_reg == XVC_ST_RX);
  assign o_prog_ready = (state_reg == XVC_ST_RX) && (cnt_reg == `XVC_CNT_ZERO) && !i_rx_valid;
  assign o_tx_valid = (state_reg == XVC_ST_TX);
  assign o_tx_byte = tx_buf_reg[FRAME_BITS+7:FRAME_BITS];
  assign o_xreg = xreg_reg;
  assign o_cmp_zero = cmp_zero_reg;
  assign o_cmp_less = cmp_less_reg;
  assign o_prog_done = done_reg;
  assign o_cksum_err = cksum_err_reg;
  assign o_foreign_instr = foreign_reg;
  assign o_peek_data = peek_reg;

  always_comb begin
    reply.host = HOST_ADDR;
    reply.target = MODULE_ADDR;
    reply.status = alu_res.legal ? `XVC_STATUS_OK : BAD_TYPE_STATUS; // R11
    reply.instr = cmd_reg.instr; // R14
    reply.value = alu_res.write_dst ? alu_res.result : alu_dst;
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rx_buf_next = rx_buf_reg;
    rx_sum_next = rx_sum_reg;
    cmd_next = cmd_reg;
    from_host_next = from_host_reg;
    tx_buf_next = tx_buf_reg;
    done_next = 1'b0;
    cksum_err_next = 1'b0;
    foreign_next = 1'b0;
    unique case (state_reg)
      XVC_ST_RX: begin
        if (i_rx_valid) begin
          if (cnt_reg == `XVC_FRAME_LEN - `XVC_CNT_ONE) begin
            cnt_next = `XVC_CNT_ZERO;
            rx_sum_next = `XVC_BYTE_ZERO;
            if (i_rx_byte != rx_sum_reg) begin
              cksum_err_next = 1'b1; // R16
            end else if (rx_frame.target != MODULE_ADDR) begin
              state_next = XVC_ST_RX;
            end else if (rx_frame.instr == `XVC_INSTR_VAR_FROM_X ||
                         rx_frame.instr == `XVC_INSTR_X_FROM_VAR) begin
              cmd_next = rx_frame;
              from_host_next = 1'b1;
              state_next = XVC_ST_EXEC;
            end else begin
              foreign_next = 1'b1;
            end
          end else begin
            cnt_next = cnt_reg + `XVC_CNT_ONE;
            rx_buf_next = {rx_buf_reg[FRAME_BITS-9:0], i_rx_byte}; // R13
            rx_sum_next = rx_sum_reg + i_rx_byte; // R16
          end
        end else if (i_prog_valid && o_prog_ready) begin
          cmd_next = i_prog_cmd; // R12
          from_host_next = 1'b0;
          state_next = XVC_ST_EXEC;
        end
      end
      XVC_ST_EXEC: begin
        if (from_host_reg) begin
          tx_buf_next = {reply, frame_sum(reply)}; // R14 R16
          cnt_next = `XVC_CNT_ZERO;
          state_next = XVC_ST_TX;
        end else begin
          done_next = 1'b1;
          state_next = XVC_ST_RX;
        end
      end
      XVC_ST_TX: begin
        if (i_tx_ready) begin
          tx_buf_next = {tx_buf_reg[FRAME_BITS-1:0], `XVC_BYTE_ZERO};
          if (cnt_reg == `XVC_FRAME_LEN - `XVC_CNT_ONE) begin
            cnt_next = `XVC_CNT_ZERO;
            state_next = XVC_ST_RX;
          end else begin
            cnt_next = cnt_reg + `XVC_CNT_ONE;
          end
        end
      end
      default: begin
        state_next = XVC_ST_RX;
        cnt_next = `XVC_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= XVC_ST_RX;
      cnt_reg <= `XVC_CNT_ZERO;
      rx_buf_reg <= '0;
      rx_sum_reg <= `XVC_BYTE_ZERO;
      cmd_reg <= '0;
      from_host_reg <= 1'b0;
      tx_buf_reg <= '0;
      done_reg <= 1'b0;
      cksum_err_reg <= 1'b0;
      foreign_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rx_buf_reg <= rx_buf_next;
      rx_sum_reg <= rx_sum_next;
      cmd_reg <= cmd_next;
      from_host_reg <= from_host_next;
      tx_buf_reg <= tx_buf_next;
      done_reg <= done_next;
      cksum_err_reg <= cksum_err_next;
      foreign_reg <= foreign_next;
    end
  end

  // The value field of the command never reaches the datapath.
  always_comb begin
    xreg_next = xreg_reg;
    cmp_zero_next = cmp_zero_reg;
    cmp_less_next = cmp_less_reg;
    var_we = '0;
    var_wdata = alu_res.result;
    peek_next = (32'(i_peek_idx) < VAR_COUNT) ? var_q[i_peek_idx] : `XVC_WORD_ZERO;
    if (state_reg == XVC_ST_EXEC && idx_ok && (is_vx || is_xv)) begin // R15
      if (alu_res.cmp_valid) begin
        cmp_zero_next = alu_res.cmp_zero; // R10
        cmp_less_next = alu_res.cmp_less; // R10
      end
      if (alu_res.swap) begin
        xreg_next = var_rd; // R06
        var_wdata = xreg_reg; // R06
        var_we[cmd_reg.var_idx] = 1'b1;
      end else if (alu_res.write_dst && is_vx) begin
        var_we[cmd_reg.var_idx] = 1'b1; // R01
      end else if (alu_res.write_dst) begin
        xreg_next = alu_res.result; // R02
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      xreg_reg <= `XVC_WORD_ZERO;
      cmp_zero_reg <= 1'b0;
      cmp_less_reg <= 1'b0;
      peek_reg <= `XVC_WORD_ZERO;
    end else begin
      xreg_reg <= xreg_next;
      cmp_zero_reg <= cmp_zero_next;
      cmp_less_reg <= cmp_less_next;
      peek_reg <= peek_next;
    end
  end

  // One register per user variable; the bank is small enough to live in flops.
  for (genvar g = 0; g < VAR_COUNT; g++) begin : g_var
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        var_q[g] <= `XVC_WORD_ZERO;
      end else if (var_we[g]) begin
        var_q[g] <= var_wdata; // R01
      end
    end
  end
endmodule

// ==== rtl/xvc_defs.svh ====
// Constants for the X register / user variable calculation command block.
// Assumes one clock domain and a byte-wide command link on that same clock.
// Notes on behaviour
// R01 - Code 43 reads the chosen user variable and X, applies the type operation, and stores into the variable.
// R02 - Code 44 combines X with the chosen user variable by the type operation and stores into X.
// R03 - The motor/bank byte is the user variable index 0 to 255 and the type byte is the operation.
// R04 - For code 43, type 0 adds X to the variable and type 1 subtracts X from the variable.
// R05 - For code 43, type 8 stores the inverse of X in the variable and type 9 copies X into it.
// R06 - For either code, type 10 exchanges the chosen variable and X.
// R07 - Types 2, 3 and 4 multiply, divide and take the remainder of the destination by the source.
// R08 - Types 5, 6 and 7 AND, OR and XOR the destination with the source into the destination.
// R09 - For code 44, type 8 loads X with the inverse of the variable and type 9 loads X with it.
// R10 - Type 11 compares the destination with the source, X against the variable for code 44.
// R11 - A command taken over the link is answered with status 100, the value being of no meaning; the block answers a type above 11 with BAD_TYPE_STATUS.
// R12 - The host is advised to use these commands mostly from a stored program run by the device.
// R13 - The host sends address, instruction, type, bank, four value bytes high first, checksum.
// R14 - The reply holds host address, target address, status, instruction, value high first, checksum.
// R15 - The value field of the command is ignored; only type and index steer the operation.
// R16 - Every frame checksum is the low byte of the sum of all bytes before it.
`ifndef XVC_DEFS_SVH
`define XVC_DEFS_SVH
`define XVC_FRAME_LEN 4'h9
`define XVC_INSTR_VAR_FROM_X 8'h2B
`define XVC_INSTR_X_FROM_VAR 8'h2C
`define XVC_STATUS_OK 8'h64
`define XVC_OP_ADD 8'h00
`define XVC_OP_SUB 8'h01
`define XVC_OP_MUL 8'h02
`define XVC_OP_DIV 8'h03
`define XVC_OP_REM 8'h04
`define XVC_OP_AND 8'h05
`define XVC_OP_OR 8'h06
`define XVC_OP_XOR 8'h07
`define XVC_OP_NOT 8'h08
`define XVC_OP_LOAD 8'h09
`define XVC_OP_SWAP 8'h0A
`define XVC_OP_COMP 8'h0B
`define XVC_WORD_ZERO 32'h0000_0000
`define XVC_BYTE_ZERO 8'h00
`define XVC_CNT_ZERO 4'h0
`define XVC_CNT_ONE 4'h1
`define XVC_BYTE_BITS 8
`endif

// ==== rtl/xvc_pkg.sv ====
// Types shared by the calculation command block and its arithmetic unit.
// Assumes the constants header is included by the design files.
package xvc_pkg;
  typedef struct packed {
    logic [7:0] target;
    logic [7:0] instr;
    logic [7:0] op;
    logic [7:0] var_idx;
    logic [31:0] value;
  } xvc_cmd_s;

  typedef struct packed {
    logic [7:0] host;
    logic [7:0] target;
    logic [7:0] status;
    logic [7:0] instr;
    logic [31:0] value;
  } xvc_reply_s;

  typedef struct packed {
    logic [31:0] result;
    logic write_dst;
    logic swap;
    logic cmp_valid;
    logic cmp_zero;
    logic cmp_less;
    logic legal;
  } xvc_alu_s;

  typedef enum logic [2:0] {
    XVC_ST_RX = 3'b001,
    XVC_ST_EXEC = 3'b010,
    XVC_ST_TX = 3'b100
  } xvc_state_e;
endpackage

// ==== rtl/xvc_alu.sv ====
// Combinational operation unit: destination and source in, new destination out.
// Assumes the caller routes variable and X register to the operand roles.
`timescale 1ns/10ps
`include "xvc_defs.svh"
module xvc_alu import xvc_pkg::*; (
  input wire logic [7:0] i_op,
  input wire logic signed [31:0] i_dst,
  input wire logic signed [31:0] i_src,
  output xvc_alu_s o_res
);
  always_comb begin
    o_res = '0;
    o_res.legal = 1'b1;
    o_res.write_dst = 1'b1;
    case (i_op)
      `XVC_OP_ADD: o_res.result = i_dst + i_src; // R04
      `XVC_OP_SUB: o_res.result = i_dst - i_src; // R04
      `XVC_OP_MUL: o_res.result = i_dst * i_src; // R07
      `XVC_OP_DIV, `XVC_OP_REM: begin
        // A zero divisor leaves the destination untouched rather than inventing a value.
        if (i_src == `XVC_WORD_ZERO) begin
          o_res.write_dst = 1'b0;
        end else if (i_op == `XVC_OP_DIV) begin
          o_res.result = i_dst / i_src; // R07
        end else begin
          o_res.result = i_dst % i_src; // R07
        end
      end
      `XVC_OP_AND: o_res.result = i_dst & i_src; // R08
      `XVC_OP_OR: o_res.result = i_dst | i_src; // R08
      `XVC_OP_XOR: o_res.result = i_dst ^ i_src; // R08
      `XVC_OP_NOT: o_res.result = ~i_src; // R05 R09
      `XVC_OP_LOAD: o_res.result = i_src; // R05 R09
      `XVC_OP_SWAP: begin
        o_res.result = i_src; // R06
        o_res.swap = 1'b1;
      end
      `XVC_OP_COMP: begin
        o_res.write_dst = 1'b0;
        o_res.cmp_valid = 1'b1; // R10
        o_res.cmp_zero = (i_dst == i_src);
        o_res.cmp_less = (i_dst < i_src);
      end
      default: begin
        o_res.legal = 1'b0;
        o_res.write_dst = 1'b0;
      end
    endcase
  end
endmodule

// ==== tb/xvc_calc_monitor.sv ====
// Checker for the calculation command block, bound to its top module.
// Assumes one clock and the synchronous active-low reset of that block.
`timescale 1ns/10ps
module xvc_calc_monitor #(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR = 8'h02,
  parameter logic [7:0] BAD_TYPE_STATUS = 8'h03
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rx_valid,
  input wire logic o_rx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  input wire logic i_prog_valid,
  input wire logic o_prog_ready,
  input wire logic o_prog_done
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_head_taken;
    $rose(o_tx_valid) && i_tx_ready;
  endsequence
  sequence s_addr_taken;
    s_head_taken ##1 i_tx_ready;
  endsequence
  a_prog_two_edges: assert property (i_prog_valid && o_prog_ready |-> ##2 o_prog_done)
    else $error("program command did not finish two edges after it was taken");
  a_done_single: assert property (o_prog_done |=> !o_prog_done)
    else $error("program done longer than one cycle");
  a_tx_byte_holds: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("reply byte changed while stalled");
  a_no_rx_in_reply: assert property (o_tx_valid |-> !o_rx_ready)
    else $error("receiver open during reply");
  a_prog_yields: assert property (o_prog_ready |-> o_rx_ready && !i_rx_valid)
    else $error("program port ready beside a link byte");
  a_reply_host: assert property ($rose(o_tx_valid) |-> o_tx_byte == HOST_ADDR)
    else $error("reply does not open with the host address");
  a_reply_target: assert property (s_head_taken |=> o_tx_byte == MODULE_ADDR)
    else $error("second reply byte is not the module address");
  a_reply_status: assert property (s_addr_taken |=> o_tx_byte inside {8'h64, BAD_TYPE_STATUS})
    else $error("reply status is not a known code");
  a_exec_then_reply: assert property ($fell(o_rx_ready) |=> o_tx_valid || o_prog_done)
    else $error("no reply or done one cycle after execution");
endmodule

bind xvc_calc xvc_calc_monitor #(.MODULE_ADDR(MODULE_ADDR), .HOST_ADDR(HOST_ADDR),
  .BAD_TYPE_STATUS(BAD_TYPE_STATUS)) u_mon (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .i_prog_valid(i_prog_valid),
  .o_prog_ready(o_prog_ready), .o_prog_done(o_prog_done));

// ==== tb/xvc_host_model.sv ====
// Host on the command link: sends binary frames and gathers reply bytes.
// Assumes the block's clock; drives on falling edges, may stall replies.
`timescale 1ns/10ps
module xvc_host_model (
  input wire logic i_clk,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_tx_ready
);
  logic [7:0] reply_q[$];
  bit slow = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_tx_ready = 1'b1;
  end
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) reply_q.push_back(i_tx_byte);
  end
  // A slow host drops ready every other cycle so the replier must hold its byte.
  always @(negedge i_clk) o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  task automatic send(input logic [63:0] body, input logic [7:0] bad);
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'h00;
    for (int k = 0; k < 9; k++) begin
      b = (k < 8) ? body[63-8*k -: 8] : sum ^ bad;
      sum = sum + b;
      @(negedge i_clk);
      o_rx_valid = 1'b1;
      o_rx_byte = b;
      while (!i_rx_ready) @(negedge i_clk);
      @(posedge i_clk);
    end
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_byte = ~b;
  endtask
endmodule

// ==== tb/xreg_user_var_calc_tb.sv ====
// Self-checking bench for the calculation command block.
// Assumes the host model on the link; the program port is driven here.
`timescale 1ns/10ps
module xreg_user_var_calc_tb import xvc_pkg::*;;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_prog_valid = 1'b0, rv, rr, tv, tr, pr, pd, cz, cl, ce, fi;
  logic [7:0] rb, tb_byte, i_peek_idx = 8'h00;
  logic [31:0] xr, pk;
  xvc_cmd_s i_prog_cmd = '0;
  logic [31:0] m_var[256] = '{default: 32'h0000_0000};
  logic [31:0] m_x = 32'h0000_0000;
  logic m_zero = 1'b0, m_less = 1'b0;
  int n_fail = 0, checked = 0, n_ck = 0, n_fi = 0;
  xvc_calc dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_rx_valid(rv), .i_rx_byte(rb),
    .o_rx_ready(rr), .o_tx_valid(tv), .o_tx_byte(tb_byte), .i_tx_ready(tr),
    .i_prog_valid(i_prog_valid), .i_prog_cmd(i_prog_cmd), .o_prog_ready(pr),
    .o_prog_done(pd), .o_xreg(xr), .o_cmp_zero(cz), .o_cmp_less(cl), .i_peek_idx(i_peek_idx),
    .o_peek_data(pk), .o_cksum_err(ce), .o_foreign_instr(fi));
  xvc_host_model host (.i_clk(i_clk), .i_rx_ready(rr), .i_tx_valid(tv), .i_tx_byte(tb_byte),
    .o_rx_valid(rv), .o_rx_byte(rb), .o_tx_ready(tr));
  initial forever #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    n_ck += ce;
    n_fi += fi;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ref_op(input logic [7:0] op,
      input logic signed [31:0] d, input logic signed [31:0] s);
    case (op)
      8'h00: return d + s;
      8'h01: return d - s;
      8'h02: return d * s;
      8'h03: return (s == 0) ? d : d / s;
      8'h04: return (s == 0) ? d : d % s;
      8'h05: return d & s;
      8'h06: return d | s;
      8'h07: return d ^ s;
      8'h08: return ~s;
      8'h09, 8'h0A: return s;
      default: return d;
    endcase
  endfunction
  task automatic model_step(input logic [7:0] ins, op, idx, output logic [31:0] r);
    logic [31:0] d, s;
    d = (ins == 8'h2B) ? m_var[idx] : m_x;
    s = (ins == 8'h2B) ? m_x : m_var[idx];
    r = ref_op(op, d, s);
    if (op == 8'h0B) begin
      m_zero = (d == s);
      m_less = ($signed(d) < $signed(s));
    end
    if (op == 8'h0A) begin
      if (ins == 8'h2B) m_x = d; else m_var[idx] = d;
    end
    if (ins == 8'h2B) m_var[idx] = r; else m_x = r;
  endtask
  task automatic check_state(input logic [7:0] idx);
    @(negedge i_clk) i_peek_idx = idx;
    @(negedge i_clk);
    check(xr, m_x);
    check(pk, m_var[idx]);
    check({cz, cl}, {m_zero, m_less});
  endtask
  task automatic link_cmd(input logic [7:0] ins, op, idx);
    logic [31:0] r;
    logic [7:0] e[9];
    model_step(ins, op, idx, r);
    host.reply_q.delete();
    host.send({8'h01, ins, op, idx, 32'h5A5A_A5A5}, 8'h00);
    e = '{8'h02, 8'h01, (op > 8'h0B) ? 8'h03 : 8'h64, ins,
      r[31:24], r[23:16], r[15:8], r[7:0], 8'h00};
    for (int k = 0; k < 8; k++) e[8] = e[8] + e[k];
    for (int k = 0; k < 60 && host.reply_q.size() < 9; k++) @(negedge i_clk);
    for (int k = 0; k < 9; k++) check(host.reply_q[k], e[k]);
    check_state(idx);
  endtask
  task automatic prog_cmd(input logic [7:0] ins, op, idx);
    logic [31:0] r;
    model_step(ins, op, idx, r);
    @(negedge i_clk);
    i_prog_valid = 1'b1;
    i_prog_cmd = {8'h01, ins, op, idx, 32'hFFFF_0000};
    for (int k = 0; k < 20 && !pr; k++) @(negedge i_clk);
    @(posedge i_clk);
    @(negedge i_clk) i_prog_valid = 1'b0;
    @(negedge i_clk) check(pd, 1'b1);
    check_state(idx);
  endtask
  task automatic t_examples();
    link_cmd(8'h2B, 8'h01, 8'h1B);
    link_cmd(8'h2C, 8'h01, 8'h1B);
  endtask
  task automatic t_all_ops();
    prog_cmd(8'h2C, 8'h08, 8'h00);
    for (int k = 0; k < 3; k++) prog_cmd(8'h2B, 8'h01, 8'h01);
    for (logic [7:0] op = 8'h00; op < 8'h0D; op++) begin
      host.slow = op[0];
      link_cmd(8'h2B, op, 8'h01);
      prog_cmd(8'h2C, op, 8'hFF);
      link_cmd(8'h2C, op, 8'h01);
      prog_cmd(8'h2B, op, 8'hFF);
    end
    host.slow = 1'b0;
  endtask
  task automatic t_bad_frames();
    int c0, f0;
    c0 = n_ck;
    f0 = n_fi;
    host.reply_q.delete();
    host.send({8'h01, 8'h2B, 8'h00, 8'h01, 32'h0000_0000}, 8'h01);
    host.send({8'h07, 8'h2B, 8'h00, 8'h01, 32'h0000_0000}, 8'h00);
    host.send({8'h01, 8'h2D, 8'h00, 8'h01, 32'h0000_0000}, 8'h00);
    repeat (20) @(negedge i_clk);
    check(n_ck - c0, 1);
    check(n_fi - f0, 1);
    check(host.reply_q.size(), 0);
    check_state(8'h01);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge i_clk);
    i_rstn = 1'b1;
    t_examples();
    t_all_ops();
    t_bad_frames();
    tally_and_finish();
  end
endmodule
